// >>> verilog/lsct_map.vh
`ifndef LSCT_MAP_VH
`define LSCT_MAP_VH

// ***************************************************************
// register offsets
// ***************************************************************
`define LSCT_ADDR_COMMAND 8'h00
`define LSCT_ADDR_RESULT_LOW 8'h01
`define LSCT_ADDR_RESULT_HIGH 8'h02
// address bit that turns a write into a sync command
`define LSCT_SYNC_ADDR_BIT 7

// ***************************************************************
// command register fields
// ***************************************************************
`define LSCT_CMD_TIMING_SOURCE_BIT 4
`define LSCT_CMD_RES_HIGH_BIT 3
`define LSCT_CMD_RES_LOW_BIT 2
`define LSCT_CMD_RESET 8'h00
`define LSCT_RESULT_RESET 8'h00

// ***************************************************************
// timing mode codes (command bits 4:2)
// ***************************************************************
`define LSCT_MODE_INT16 3'h0
`define LSCT_MODE_INT12 3'h1
`define LSCT_MODE_INT8 3'h2
`define LSCT_MODE_INT4 3'h3
`define LSCT_MODE_EXT_ADC 3'h4
`define LSCT_MODE_EXT_TIMER 3'h5

// ***************************************************************
// integration counts in oscillator cycles
// ***************************************************************
`define LSCT_CYCLES_16 17'h10000
`define LSCT_CYCLES_12 17'h01000
`define LSCT_CYCLES_8 17'h00100
`define LSCT_CYCLES_4 17'h00010
`define LSCT_TIMER_LIMIT 16'hFFFF

`endif

// >>> verilog/lsct_core.v
`timescale 1ns/10ps
`default_nettype none

`include "lsct_map.vh"

module lsct_core #(
   parameter DATA_WIDTH = 16,
   parameter SYNC_STAGES = 3
) (
   // clock and reset
   input wire i_clk,
   input wire i_arst_n,
   // register write port from the serial slave
   input wire i_wr_en,
   input wire [7:0] i_wr_addr,
   input wire [7:0] i_wr_data,
   // register read port from the serial slave
   input wire i_rd_en,
   input wire [7:0] i_rd_addr,
   output reg [7:0] o_rd_data,
   // analog front end pins
   input wire i_osc_clock,
   input wire i_charge_pulse,
   // status
   output reg o_integrating,
   output reg o_conv_done
);

   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   // both pins use the same synchroniser depth, so a charge tick never outruns its oscillator tick
   wire [1:0] pin_raw;
   wire [1:0] pin_rise;
   assign pin_raw = {i_charge_pulse, i_osc_clock};

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_pin
         reg [SYNC_STAGES-1:0] sync_pipe;
         reg pin_level;
         // three stages; only the agreeing later two feed the edge detect
         always @(posedge i_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               sync_pipe <= {SYNC_STAGES{1'b0}};
            end else begin
               sync_pipe <= {sync_pipe[SYNC_STAGES-2:0], pin_raw[g]};
            end
         end
         // the counted level moves only while stages two and three agree
         always @(posedge i_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               pin_level <= 1'b0;
            end else if (sync_pipe[1] == sync_pipe[2]) begin
               pin_level <= sync_pipe[2];
            end
         end
         // a rise counts in the cycle the later two stages first agree high
         assign pin_rise[g] = sync_pipe[1] & sync_pipe[2] & ~pin_level;
      end
   endgenerate

   wire osc_tick;
   wire charge_tick;
   assign osc_tick = pin_rise[0];
   assign charge_tick = pin_rise[1];

   // ***************************************************************
   // command register and decode
   // ***************************************************************
   reg [7:0] command;
   wire cmd_write;
   wire sync_cmd;
   wire [2:0] timing_mode;
   wire timing_source_select;
   wire ext_mode;
   wire int_mode;
   wire mode_change;

   assign cmd_write = i_wr_en && !i_wr_addr[`LSCT_SYNC_ADDR_BIT] && (i_wr_addr == `LSCT_ADDR_COMMAND);
   assign sync_cmd = i_wr_en && i_wr_addr[`LSCT_SYNC_ADDR_BIT];
   assign timing_mode = command[`LSCT_CMD_TIMING_SOURCE_BIT:`LSCT_CMD_RES_LOW_BIT];
   assign timing_source_select = command[`LSCT_CMD_TIMING_SOURCE_BIT];
   // reserved codes 110 and 111 run neither timing scheme
   assign ext_mode = (timing_mode == `LSCT_MODE_EXT_ADC) || (timing_mode == `LSCT_MODE_EXT_TIMER);
   assign int_mode = !timing_source_select;
   // a new timing code abandons the running integration
   assign mode_change = cmd_write &&
      (i_wr_data[`LSCT_CMD_TIMING_SOURCE_BIT:`LSCT_CMD_RES_LOW_BIT] != timing_mode);

   // bits 7 to 5 and 1 to 0 are stored for readback only; they steer nothing here
   // command register; result registers are read-only so other writes drop
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         command <= `LSCT_CMD_RESET;
      end else if (cmd_write) begin
         command <= i_wr_data;
      end
   end

   // ***************************************************************
   // internal integration length
   // ***************************************************************
   reg [16:0] int_cycles;
   reg [16:0] int_max_count;
   // the ceiling sits one below the cycle count, so full scale reads as 2^n-1
   // resolution select bits 3:2 give 2^n cycles and an n-bit ceiling
   always @* begin
      case (command[`LSCT_CMD_RES_HIGH_BIT:`LSCT_CMD_RES_LOW_BIT])
         2'h0: int_cycles = `LSCT_CYCLES_16;
         2'h1: int_cycles = `LSCT_CYCLES_12;
         2'h2: int_cycles = `LSCT_CYCLES_8;
         default: int_cycles = `LSCT_CYCLES_4;
      endcase
      int_max_count = int_cycles - 17'h00001;
   end

   // ***************************************************************
   // integration counters
   // ***************************************************************
   reg [16:0] osc_count;
   reg [16:0] charge_count;
   reg ext_running;
   wire int_end;
   wire ext_end;
   wire conv_end;
   wire restart;
   wire [16:0] charge_next;
   wire [16:0] osc_next;

   // internal interval closes on the oscillator edge that makes 2^n
   assign int_end = int_mode && osc_tick && (osc_count == int_max_count);
   // external interval closes only on a sync after the first one
   assign ext_end = ext_mode && ext_running && sync_cmd;
   assign conv_end = int_end || ext_end;
   // the sync that ends one interval starts the next on the same edge
   assign restart = conv_end || mode_change || (ext_mode && sync_cmd);
   assign charge_next = charge_count + {16'h0000, charge_tick};
   assign osc_next = osc_count + 17'h00001;

   // a sync and a command write never share a cycle, so no priority is lost here
   // external run flag: first sync arms it, mode change drops it
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ext_running <= 1'b0;
      end else if (mode_change) begin
         ext_running <= 1'b0;
      end else if (ext_mode && sync_cmd) begin
         ext_running <= 1'b1;
      end
   end

   // oscillator cycle counter; same tick source in either mode
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         osc_count <= 17'h00000;
      end else if (restart) begin
         osc_count <= 17'h00000;
      end else if (osc_tick && (int_mode || ext_running)) begin
         // external count stops at the 16-bit ceiling rather than wrap
         // a saturated count means the host spaced its syncs too far apart
         if (ext_mode && (osc_count[15:0] == `LSCT_TIMER_LIMIT)) begin
            osc_count <= osc_count;
         end else begin
            osc_count <= osc_next;
         end
      end
   end

   // charge pulse counter, the conversion value itself
   // counting is held off in the reserved codes and before the first sync
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         charge_count <= 17'h00000;
      end else if (restart) begin
         charge_count <= 17'h00000;
      end else if (int_mode || ext_running) begin
         if (charge_next > {1'b0, `LSCT_TIMER_LIMIT}) begin
            charge_count <= {1'b0, `LSCT_TIMER_LIMIT};
         end else begin
            charge_count <= charge_next;
         end
      end
   end

   // ***************************************************************
   // conversion captures
   // ***************************************************************
   reg [DATA_WIDTH-1:0] adc_capture;
   reg [DATA_WIDTH-1:0] timer_capture;
   wire [16:0] adc_clamped;
   wire [DATA_WIDTH-1:0] adc_final;
   wire [DATA_WIDTH-1:0] timer_final;

   // internal result cannot exceed n bits
   assign adc_clamped = (int_mode && (charge_count > int_max_count)) ? int_max_count : charge_count;
   assign adc_final = adc_clamped[DATA_WIDTH-1:0];
   assign timer_final = osc_count[DATA_WIDTH-1:0];

   // keep both values of the last interval so a later code swap can show either
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         adc_capture <= {DATA_WIDTH{1'b0}};
         timer_capture <= {DATA_WIDTH{1'b0}};
      end else if (conv_end) begin
         adc_capture <= adc_final;
         timer_capture <= timer_final;
      end
   end

   // ***************************************************************
   // result registers
   // ***************************************************************
   reg [7:0] result_low_byte;
   reg [7:0] result_high_byte;
   reg [DATA_WIDTH-1:0] result_pick;
   wire show_timer;
   wire reload;
   wire new_code_ext;
   wire code_swap;

   assign show_timer = (timing_mode == `LSCT_MODE_EXT_TIMER);
   // a swap keeps timing external: new bit 4 set, new bit 3 clear, code differs
   assign new_code_ext = i_wr_data[`LSCT_CMD_TIMING_SOURCE_BIT] && !i_wr_data[`LSCT_CMD_RES_HIGH_BIT];
   assign code_swap = mode_change && ext_mode && new_code_ext;
   // swapping between external ADC and timer codes re-presents the held interval
   assign reload = code_swap;

   // source for the byte pair: fresh values at end, held values on reload
   always @* begin
      if (conv_end) begin
         result_pick = show_timer ? timer_final : adc_final;
      end else if (i_wr_data[`LSCT_CMD_RES_LOW_BIT]) begin
         result_pick = timer_capture;
      end else begin
         result_pick = adc_capture;
      end
   end

   // a reload needs a command write and an end needs a sync or internal timing, so they never meet
   // both bytes load in the same edge, never one without the other
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         result_low_byte <= `LSCT_RESULT_RESET;
         result_high_byte <= `LSCT_RESULT_RESET;
      end else if (conv_end || reload) begin
         result_low_byte <= result_pick[7:0];
         result_high_byte <= result_pick[15:8];
      end
   end

   // ***************************************************************
   // read port and status
   // ***************************************************************
   // reads have no side effects, so the host may poll the result bytes freely
   // read data appears one edge after the request; unmapped reads give zero
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rd_data <= 8'h00;
      end else if (i_rd_en) begin
         if (i_rd_addr == `LSCT_ADDR_COMMAND) begin
            o_rd_data <= command;
         end else if (i_rd_addr == `LSCT_ADDR_RESULT_LOW) begin
            o_rd_data <= result_low_byte;
         end else if (i_rd_addr == `LSCT_ADDR_RESULT_HIGH) begin
            o_rd_data <= result_high_byte;
         end else begin
            o_rd_data <= 8'h00;
         end
      end
   end

   // integrating rises on the edge of the arming sync, the same edge that sets the run flag
   // status flags for the surrounding control logic
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_integrating <= 1'b0;
         o_conv_done <= 1'b0;
      end else begin
         o_integrating <= int_mode || ext_running || (ext_mode && sync_cmd);
         o_conv_done <= conv_end;
      end
   end

endmodule // lsct_core

`default_nettype wire

// >>> testbench/lsct_core_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ***************************************************************
// port checks of the conversion timing core
// ***************************************************************
module lsct_core_properties (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // register ports
   input wire logic i_wr_en,
   input wire logic [7:0] i_wr_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_rd_en,
   input wire logic [7:0] i_rd_addr,
   input wire logic [7:0] o_rd_data,
   // pins and status
   input wire logic i_osc_clock,
   input wire logic i_charge_pulse,
   input wire logic o_integrating,
   input wire logic o_conv_done
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   logic [2:0] code;
   // mirror of the timing code, taken from the write port so it never trusts the core
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n)
         code <= 3'h0;
      else if (i_wr_en && i_wr_addr == 8'h00)
         code <= i_wr_data[4:2];
   end
   sequence cmd_write;
      i_wr_en && i_wr_addr == 8'h00;
   endsequence
   sequence cmd_read;
      i_rd_en && i_rd_addr == 8'h00 && !i_wr_en;
   endsequence
   a_done_one_cycle: assert property (o_conv_done |=> !o_conv_done)
      else $error("done pulse longer than one cycle");
   a_done_spacing: assert property (!code[2] && o_conv_done |=> !o_conv_done [*8])
      else $error("internal conversions too close");
   a_rd_unmapped: assert property (i_rd_en && i_rd_addr > 8'h02 |=> o_rd_data == 8'h00)
      else $error("unmapped read not zero");
   a_rd_hold: assert property (!i_rd_en |=> $stable(o_rd_data))
      else $error("read data moved without a read");
   a_cmd_readback: assert property (
      cmd_write ##1 !i_wr_en ##1 cmd_read |=> o_rd_data == $past(i_wr_data, 3))
      else $error("command readback wrong");
   a_sync_starts: assert property (i_wr_en && i_wr_addr[7] && code[2:1] == 2'b10 |=> o_integrating)
      else $error("sync did not start integration");
   a_reserved_quiet: assert property (code[2:1] == 2'b11 |=> !o_conv_done)
      else $error("conversion in reserved mode");
   a_int_running: assert property (!code[2] && $stable(code) |=> o_integrating)
      else $error("internal mode not integrating");
   a_done_after_integ: assert property ($rose(o_conv_done) |-> $past(o_integrating))
      else $error("done without an interval");
endmodule // lsct_core_properties
`default_nettype wire

// >>> testbench/lsct_host.sv
`timescale 1ns/10ps
`default_nettype none
// ***************************************************************
// bus master and front end model
// ***************************************************************
module lsct_host (
   // clock
   input wire logic i_clk,
   // register side
   output logic o_wr_en,
   output logic [7:0] o_wr_addr,
   output logic [7:0] o_wr_data,
   output logic o_rd_en,
   output logic [7:0] o_rd_addr,
   input wire logic [7:0] i_rd_data,
   // front end pins
   output logic o_osc_clock,
   output logic o_charge_pulse
);
   initial begin
      {o_wr_en, o_rd_en, o_osc_clock, o_charge_pulse} = 4'h0;
      {o_wr_addr, o_wr_data, o_rd_addr} = 24'h000000;
   end
   // one write; an address with bit 7 set is a sync command
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_wr_en = 1'b1;
      o_wr_addr = a;
      o_wr_data = d;
      @(negedge i_clk);
      o_wr_en = 1'b0;
      // released lines flip so stale values never pass for data
      o_wr_addr = ~a;
      o_wr_data = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_clk);
      o_rd_en = 1'b1;
      o_rd_addr = a;
      @(negedge i_clk);
      o_rd_en = 1'b0;
      o_rd_addr = ~a;
      d = i_rd_data;
   endtask
   // one oscillator cycle, two clocks high and two low for the pin synchroniser
   task automatic pulse(input logic chg);
      @(negedge i_clk);
      o_osc_clock = 1'b1;
      o_charge_pulse = chg;
      repeat (2) @(negedge i_clk);
      o_osc_clock = 1'b0;
      o_charge_pulse = 1'b0;
      @(negedge i_clk);
   endtask
endmodule // lsct_host
`default_nettype wire

// >>> testbench/light_sensor_conversion_timing_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ***************************************************************
// conversion timing bench
// ***************************************************************
module light_sensor_conversion_timing_tb;
   logic clk, arst_n, wr_en, rd_en, osc, chg, integ, done;
   logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
   int fails = 0, n_checks = 0, n_done = 0;
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   lsct_core i_dut (.i_clk(clk), .i_arst_n(arst_n), .i_wr_en(wr_en), .i_wr_addr(wr_addr),
      .i_wr_data(wr_data), .i_rd_en(rd_en), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
      .i_osc_clock(osc), .i_charge_pulse(chg), .o_integrating(integ), .o_conv_done(done));
   lsct_host i_host (.i_clk(clk), .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
      .o_rd_en(rd_en), .o_rd_addr(rd_addr), .i_rd_data(rd_data), .o_osc_clock(osc), .o_charge_pulse(chg));
   // done pulses are counted here because they may land inside a pulse task
   always @(posedge clk) begin
      if (done === 1'b1)
         n_done <= n_done + 1;
   end
   function automatic logic [7:0] cmd(input logic [2:0] c);
      return {3'b100, c, 2'b00};
   endfunction
   function automatic int cycles(input int c);
      return 1 << (16 - 4 * c);
   endfunction
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int exp);
      n_checks++;
      if (got != exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %0d done pulses expected %0d", $time, got, exp);
      end
   endtask
   task automatic rd16(output logic [15:0] v);
      logic [7:0] lo, hi;
      i_host.rd(8'h01, lo);
      i_host.rd(8'h02, hi);
      v = {hi, lo};
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // watchdog: the sequence needs about 20,000 cycles
   initial begin
      #600000;
      fails++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      close_out();
   end
   initial begin
      logic [15:0] v;
      logic [7:0] b;
      int k, n, base;
      arst_n = 1'b0;
      void'($urandom(77347));
      repeat (3) @(negedge clk);
      arst_n = 1'b1;
      i_host.rd(8'h03, b);
      chk_val({8'h00, b}, 16'h0000);
      // internal timing; the 16-bit count is only set and read back, it is too long to run
      for (int c = 0; c <= 3; c++) begin
         n = cycles(c);
         k = (c == 3) ? 15 : $urandom_range(0, n - 1);
         i_host.wr(8'h00, cmd(c[2:0]));
         i_host.rd(8'h00, b);
         chk_val({8'h00, b}, {8'h00, cmd(c[2:0])});
         if (c == 0) continue;
         base = n_done;
         for (int i = 0; i < n; i++) begin
            if (i == n / 2) i_host.wr(8'h80, 8'h00);
            i_host.pulse(i < k);
         end
         repeat (6) @(negedge clk);
         chk_cnt(n_done - base, 1);
         rd16(v);
         chk_val(v, k[15:0]);
      end
      i_host.wr(8'h01, 8'h5A);
      rd16(v);
      chk_val(v, 16'h000F);
      // external timing, sync spacing kept far below the counter limit
      for (int r = 0; r < 2; r++) begin
         n = $urandom_range(200, 300);
         k = (r == 0) ? n : $urandom_range(0, n);
         i_host.wr(8'h00, cmd(3'h4));
         i_host.wr(8'h80, 8'h00);
         chk_val({15'h0000, integ}, 16'h0001);
         for (int i = 0; i < n; i++) i_host.pulse(i < k);
         base = n_done;
         i_host.wr(8'h80, 8'h00);
         repeat (3) @(negedge clk);
         chk_cnt(n_done - base, 1);
         rd16(v);
         chk_val(v, k[15:0]);
         i_host.wr(8'h00, cmd(3'h5));
         rd16(v);
         chk_val(v, n[15:0]);
         i_host.wr(8'h00, cmd(3'h4));
         rd16(v);
         chk_val(v, k[15:0]);
      end
      // reserved codes convert nothing and leave the result alone
      for (int c = 6; c < 8; c++) begin
         i_host.wr(8'h00, cmd(c[2:0]));
         base = n_done;
         repeat (20) i_host.pulse(1'b1);
         chk_cnt(n_done - base, 0);
         chk_val({15'h0000, integ}, 16'h0000);
         rd16(v);
         chk_val(v, k[15:0]);
      end
      close_out();
   end
endmodule // light_sensor_conversion_timing_tb
bind lsct_core lsct_core_properties i_props (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_wr_en(i_wr_en),
   .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr),
   .o_rd_data(o_rd_data), .i_osc_clock(i_osc_clock), .i_charge_pulse(i_charge_pulse),
   .o_integrating(o_integrating), .o_conv_done(o_conv_done));
`default_nettype wire
